// ===== rtl/irq_gather.sv
// Purpose: interrupt flag, enable and edge logic with AHB-Lite register access
// Assumes: HCLK equal to MCLK, single word transfers, pins synchronous to MCLK
// Notes: flags clear only by writing 0 after they were read as 1
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
`include "irq_gather_params.svh"
module irq_gather
(
    // clock, enable and reset
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic CE,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // pins and peripheral events
    input wire irq_gather_pkg::pin_in_t PINS,
    input wire irq_gather_pkg::event_in_t EVENTS,
    // requests to the cpu core
    output irq_gather_pkg::cpu_req_t CPU_REQ,
    output logic IRQ
);
    import irq_gather_pkg::*;

    typedef struct packed {
        ahb_state_t bus;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic [4:0] edge_ctrl;
        logic [9:0] src_en;
        logic [7:0] flags_one;
        logic [1:0] flags_two;
        logic [7:0] wakeup;
        logic [12:0] pin_mode;
        logic [7:0] seen_one;
        logic [1:0] seen_two;
        logic [7:0] seen_wk;
        logic [9:0] irq_stat;
        logic [9:0] irq_en;
        logic [6:0] ev_q;
        cpu_req_t req;
        logic irq;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;
    logic [1:0] rst_sync;
    logic rst_n;
    logic tick;
    logic [4:0] ext_edge;
    logic [7:0] wk_edge;
    logic [4:0] ext_set;
    logic [7:0] wk_set;
    logic timer_a_set;
    logic serial_one_set;
    logic adc_set;
    logic dx_set;
    logic [9:0] src_flag;
    logic [9:0] events_now;

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    sample_tick u_tick
    (
        .clk(MCLK),
        .rst_n(rst_n),
        .ce(CE),
        .fast(st.edge_ctrl[`NOISE_SEL_BIT]),
        .tick(tick)
    );

    // pin 0 has no edge bit and is fixed to falling; wakeup pins always falling
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_ext
            pin_edge u_ext
            (
                .clk(MCLK),
                .rst_n(rst_n),
                .ce(CE),
                .tick(tick),
                .pin(PINS.ext_pin[gi]),
                .rising((gi == 0) ? 1'b0 : st.edge_ctrl[gi]),
                .edge_seen(ext_edge[gi])
            );
        end
        for (gi = 0; gi < 8; gi++)
        begin : g_wk
            pin_edge u_wk
            (
                .clk(MCLK),
                .rst_n(rst_n),
                .ce(CE),
                .tick(tick),
                .pin(PINS.wakeup_pin[gi]),
                .rising(1'b0),
                .edge_seen(wk_edge[gi])
            );
        end
    endgenerate

    always_comb
    begin
        ext_set = ext_edge & st.pin_mode[4:0];
        wk_set = wk_edge & st.pin_mode[12:5];
        serial_one_set = EVENTS.serial_one_done & ~st.ev_q[0];
        timer_a_set = EVENTS.timer_a_wrap & ~st.ev_q[1];
        adc_set = EVENTS.adc_done & ~EVENTS.conversion_start_bit & ~st.ev_q[2];
        dx_set = EVENTS.sleep_exec & EVENTS.direct_xfer_on
            & EVENTS.direct_xfer_cond & ~st.ev_q[3];
        src_flag = '0;
        src_flag[`EN_SERIAL_ONE] = st.flags_one[`BIT_SERIAL_ONE_FLAG];
        src_flag[`EN_TIMER_A] = st.flags_one[`BIT_TIMER_A_FLAG];
        src_flag[`EN_ADC] = st.flags_two[`BIT_ADC_FLAG];
        src_flag[`EN_DIRECT_XFER] = st.flags_two[`BIT_DIRECT_XFER_FLAG];
        events_now = '0;
        events_now[`EN_SERIAL_ONE] = serial_one_set;
        events_now[`EN_TIMER_A] = timer_a_set;
        events_now[`EN_ADC] = adc_set;
        events_now[`EN_DIRECT_XFER] = dx_set;
        events_now[2] = |ext_set;
        events_now[3] = |wk_set;
    end

    always_comb
    begin
        next_st = st;
        next_st.ev_q = {3'b000, dx_set | (st.ev_q[3] & EVENTS.sleep_exec),
            EVENTS.adc_done & ~EVENTS.conversion_start_bit,
            EVENTS.timer_a_wrap, EVENTS.serial_one_done};
        next_st.bus = AHB_IDLE;
        // register writes happen in the data phase; clears precede sets so sets win
        if (st.bus == AHB_WRITE)
        begin
            case (st.addr)
                `OFS_EDGE_CTRL: next_st.edge_ctrl = HWDATA[4:0];
                `OFS_SRC_ENABLE: next_st.src_en = HWDATA[9:0];
                `OFS_FLAGS_ONE: next_st.flags_one = st.flags_one
                    & ~(st.seen_one & ~HWDATA[7:0]);
                `OFS_FLAGS_TWO: next_st.flags_two = st.flags_two
                    & ~(st.seen_two & ~HWDATA[1:0]);
                `OFS_WAKEUP_FLAGS: next_st.wakeup = st.wakeup
                    & ~(st.seen_wk & ~HWDATA[7:0]);
                `OFS_PIN_MODE: next_st.pin_mode = HWDATA[12:0];
                `OFS_IRQ_CLEAR: next_st.irq_stat = st.irq_stat & ~HWDATA[9:0];
                `OFS_IRQ_ENABLE: next_st.irq_en = HWDATA[9:0];
                default: next_st.irq_en = st.irq_en;
            endcase
        end
        // hardware sets
        next_st.flags_one[4:0] = next_st.flags_one[4:0] | ext_set;
        next_st.flags_one[`BIT_SERIAL_ONE_FLAG] = next_st.flags_one[`BIT_SERIAL_ONE_FLAG]
            | serial_one_set;
        next_st.flags_one[`BIT_TIMER_A_FLAG] = next_st.flags_one[`BIT_TIMER_A_FLAG]
            | timer_a_set;
        next_st.flags_one[`BIT_RESERVED_ONE] = 1'b1;
        next_st.flags_two[`BIT_ADC_FLAG] = next_st.flags_two[`BIT_ADC_FLAG] | adc_set;
        next_st.flags_two[`BIT_DIRECT_XFER_FLAG] = next_st.flags_two[`BIT_DIRECT_XFER_FLAG]
            | dx_set;
        next_st.wakeup = next_st.wakeup | wk_set;
        next_st.irq_stat = next_st.irq_stat | events_now;
        // a cleared flag must be read as 1 again before another 0 write clears it
        next_st.seen_one = st.seen_one & next_st.flags_one;
        next_st.seen_two = st.seen_two & next_st.flags_two;
        next_st.seen_wk = st.seen_wk & next_st.wakeup;
        next_st.rdata = 32'h0000_0000;
        if (HSEL && HREADY && HTRANS[1])
        begin
            next_st.addr = HADDR;
            next_st.bus = HWRITE ? AHB_WRITE : AHB_READ;
            if (!HWRITE)
            begin
                case (HADDR)
                    `OFS_EDGE_CTRL: next_st.rdata = {27'h0, st.edge_ctrl};
                    `OFS_SRC_ENABLE: next_st.rdata = {22'h0, st.src_en};
                    `OFS_FLAGS_ONE:
                    begin
                        next_st.rdata = {24'h0, st.flags_one};
                        next_st.seen_one = st.flags_one;
                    end
                    `OFS_FLAGS_TWO:
                    begin
                        next_st.rdata = {30'h0, st.flags_two};
                        next_st.seen_two = st.flags_two;
                    end
                    `OFS_WAKEUP_FLAGS:
                    begin
                        next_st.rdata = {24'h0, st.wakeup};
                        next_st.seen_wk = st.wakeup;
                    end
                    `OFS_PIN_MODE: next_st.rdata = {19'h0, st.pin_mode};
                    `OFS_IRQ_STATUS: next_st.rdata = {22'h0, st.irq_stat};
                    `OFS_IRQ_ENABLE: next_st.rdata = {22'h0, st.irq_en};
                    `OFS_OUT_STATE: next_st.rdata = {9'h0, st.req};
                    default: next_st.rdata = 32'h0000_0000;
                endcase
            end
        end
        next_st.req.src = src_flag & st.src_en;
        next_st.req.ext = st.flags_one[4:0];
        next_st.req.wakeup = st.wakeup;
        next_st.irq = |(st.irq_stat & st.irq_en);
    end

    always_ff @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.bus <= AHB_IDLE;
            st.flags_one <= `FLAGS_ONE_RESET;
            st.flags_two <= 2'(`FLAGS_TWO_RESET);
            st.wakeup <= `WAKEUP_RESET;
        end
        else if (CE)
            st <= next_st;
    end

    assign HRDATA = st.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign CPU_REQ = st.req;
    assign IRQ = st.irq;
endmodule

// ===== pkg/irq_gather_params.svh
// Purpose: offsets, field positions, reset values and counts of the interrupt gathering block
// Assumes: AHB-Lite byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef IRQ_GATHER_PARAMS_SVH
`define IRQ_GATHER_PARAMS_SVH

`define OFS_EDGE_CTRL 8'h00
`define OFS_SRC_ENABLE 8'h04
`define OFS_FLAGS_ONE 8'h08
`define OFS_FLAGS_TWO 8'h0C
`define OFS_WAKEUP_FLAGS 8'h10
`define OFS_PIN_MODE 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_CLEAR 8'h1C
`define OFS_IRQ_ENABLE 8'h20
`define OFS_OUT_STATE 8'h24

`define EDGE_SEL_LSB 1
`define NOISE_SEL_BIT 0

`define BIT_TIMER_A_FLAG 7
`define BIT_SERIAL_ONE_FLAG 6
`define BIT_RESERVED_ONE 5
`define BIT_ADC_FLAG 0
`define BIT_DIRECT_XFER_FLAG 1

`define EN_SERIAL_ONE 0
`define EN_TIMER_A 1
`define EN_TIMER_B 2
`define EN_TIMER_C 3
`define EN_TIMER_FL 4
`define EN_TIMER_FH 5
`define EN_TIMER_G 6
`define EN_SERIAL_TWO 7
`define EN_ADC 8
`define EN_DIRECT_XFER 9

`define FLAGS_ONE_RESET 8'h20
`define FLAGS_TWO_RESET 8'h00
`define WAKEUP_RESET 8'h00

`define SLOW_SAMPLE_DIV 16
`define FAST_SAMPLE_DIV 4

`endif

// ===== pkg/irq_gather_pkg.sv
// Purpose: types shared by the interrupt gathering block
// Assumes: nothing
// Notes: numbers live in irq_gather_params.svh
package irq_gather_pkg;

    typedef struct packed {
        logic [4:0] ext_pin;
        logic [7:0] wakeup_pin;
    } pin_in_t;

    typedef struct packed {
        logic serial_one_done;
        logic timer_a_wrap;
        logic adc_done;
        logic conversion_start_bit;
        logic sleep_exec;
        logic direct_xfer_on;
        logic direct_xfer_cond;
    } event_in_t;

    typedef struct packed {
        logic [9:0] src;
        logic [4:0] ext;
        logic [7:0] wakeup;
    } cpu_req_t;

    typedef enum logic [2:0]
    {
        AHB_IDLE = 3'b001,
        AHB_WRITE = 3'b010,
        AHB_READ = 3'b100
    } ahb_state_t;

endpackage

// ===== rtl/sample_tick.sv
// Purpose: sampling strobe for the noise filter, osc/16 or osc/4
// Assumes: clk is the oscillator clock
// Notes: divider restarts its count only on wrap
`timescale 1ns/10ps
`include "irq_gather_params.svh"
module sample_tick
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // control
    input wire logic fast,
    // strobe
    output logic tick
);
    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } tick_state_t;

    tick_state_t st;
    tick_state_t next_st;
    logic [3:0] last;

    always_comb
    begin
        last = fast ? 4'(`FAST_SAMPLE_DIV - 1) : 4'(`SLOW_SAMPLE_DIV - 1);
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt >= last)
        begin
            next_st.cnt = 4'h0;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else if (ce)
            st <= next_st;
    end

    assign tick = st.tick;
endmodule

// ===== rtl/pin_edge.sv
// Purpose: filter one pin with a two-sample agreement, then find the chosen edge
// Assumes: pin synchronous to clk
// Notes: a glitch shorter than one sample period is dropped
`timescale 1ns/10ps
module pin_edge
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // sampling and control
    input wire logic tick,
    input wire logic pin,
    input wire logic rising,
    // result
    output logic edge_seen
);
    typedef struct packed {
        logic samp;
        logic level;
        logic edge_seen;
    } edge_state_t;

    edge_state_t st;
    edge_state_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.edge_seen = 1'b0;
        if (tick)
        begin
            next_st.samp = pin;
            if (pin == st.samp && pin != st.level)
            begin
                next_st.level = pin;
                next_st.edge_seen = (pin == rising);
            end
        end
    end

    // idle level high, so no edge is reported out of reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= 3'b110;
        else if (ce)
            st <= next_st;
    end

    assign edge_seen = st.edge_seen;
endmodule

// ===== sim/irq_gather_props.sv
// Purpose: port-level properties of irq_gather
// Assumes: one clock MCLK, RESETN active low
// Notes: small saturating counters stand in for long waits
`timescale 1ns/10ps
module irq_gather_props
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // bus
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // pins, events and requests
    input wire irq_gather_pkg::pin_in_t PINS,
    input wire irq_gather_pkg::event_in_t EVENTS,
    input wire irq_gather_pkg::cpu_req_t CPU_REQ,
    input wire logic IRQ
);
    import irq_gather_pkg::*;
    logic acc;
    logic rd_ph;
    logic [7:0] wr_age;
    logic [7:0] quiet;
    logic [7:0] calm;
    pin_in_t prev_pins;
    event_in_t prev_ev;
    assign acc = HSEL && HREADY && HTRANS[1];
    // saturating ages: 64 cycles exceeds two slow sample periods plus margin
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rd_ph <= 1'b0;
            wr_age <= 8'hFF;
            quiet <= 8'h00;
            calm <= 8'h00;
            prev_pins <= '0;
            prev_ev <= '0;
        end
        else
        begin
            prev_pins <= PINS;
            prev_ev <= EVENTS;
            rd_ph <= acc && !HWRITE;
            wr_age <= (acc && HWRITE) ? 8'h00 : wr_age + {7'h00, wr_age != 8'hFF};
            quiet <= (PINS != prev_pins) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
            calm <= (acc || PINS != prev_pins || EVENTS != prev_ev) ? 8'h00
                : calm + {7'h00, calm != 8'hFF};
        end
    end
    a_ready_okay: assert property (@(posedge MCLK) disable iff (!RESETN)
        HREADYOUT && !HRESP) else $error("slave not ready or not okay");
    a_rdata_idle: assert property (@(posedge MCLK) disable iff (!RESETN)
        !rd_ph |-> HRDATA == 32'h0000_0000) else $error("read data outside data phase");
    a_reset_clear: assert property (@(posedge MCLK) disable iff (1'b0)
        !RESETN |-> CPU_REQ == '0 && !IRQ) else $error("requests not clear in reset");
    a_pin_quiet: assert property (@(posedge MCLK) disable iff (!RESETN)
        quiet >= 8'd64 |-> ({CPU_REQ.ext, CPU_REQ.wakeup}
        & ~$past({CPU_REQ.ext, CPU_REQ.wakeup})) == '0) else $error("flag set without edge");
    a_calm_stable: assert property (@(posedge MCLK) disable iff (!RESETN)
        calm >= 8'd64 |-> $stable(CPU_REQ) && $stable(IRQ)) else $error("change while calm");
    a_src_fall: assert property (@(posedge MCLK) disable iff (!RESETN)
        (|($past(CPU_REQ.src) & ~CPU_REQ.src)) |-> wr_age <= 8'd6)
        else $error("source request fell without write");
    a_flag_fall: assert property (@(posedge MCLK) disable iff (!RESETN)
        (|($past({CPU_REQ.ext, CPU_REQ.wakeup}) & ~{CPU_REQ.ext, CPU_REQ.wakeup}))
        |-> wr_age <= 8'd6) else $error("flag fell without write");
    a_irq_fall: assert property (@(posedge MCLK) disable iff (!RESETN)
        $fell(IRQ) |-> wr_age <= 8'd6) else $error("irq fell without write");
endmodule
bind irq_gather irq_gather_props i_irq_gather_props
(
    .MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .PINS(PINS), .EVENTS(EVENTS), .CPU_REQ(CPU_REQ), .IRQ(IRQ)
);

// ===== sim/irq_sources.sv
// Purpose: model of the peripheral event sources
// Assumes: an event is the rising edge of its line
// Notes: slow stretches pulses, so only edges may count
`timescale 1ns/10ps
module irq_sources
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // commands
    input wire logic [3:0] kick,
    input wire logic slow,
    input wire logic start_busy,
    input wire logic dx_on,
    input wire logic dx_cond,
    // event lines
    output irq_gather_pkg::event_in_t ev
);
    import irq_gather_pkg::*;
    logic [1:0] cnt [4];
    always_ff @(posedge clk or negedge rst_n)
    begin
        for (int k = 0; k < 4; k++)
        begin
            if (!rst_n)
                cnt[k] <= 2'h0;
            else if (kick[k])
                cnt[k] <= slow ? 2'h3 : 2'h1;
            else if (cnt[k] != 2'h0)
                cnt[k] <= cnt[k] - 2'h1;
        end
    end
    always_comb
    begin
        ev.serial_one_done = cnt[0] != 2'h0;
        ev.timer_a_wrap = cnt[1] != 2'h0;
        ev.adc_done = cnt[2] != 2'h0;
        ev.conversion_start_bit = start_busy;
        ev.sleep_exec = cnt[3] != 2'h0;
        ev.direct_xfer_on = dx_on;
        ev.direct_xfer_cond = dx_cond;
    end
endmodule

// ===== sim/irq_gather_tb.sv
// Purpose: self-checking bench of irq_gather over AHB-Lite
// Assumes: flags are read before they are cleared
// Notes: a monitor checks read data against queued notes
`timescale 1ns/10ps
`include "irq_gather_params.svh"
module irq_gather_tb;
    import irq_gather_pkg::*;
    logic MCLK = 1'b0;
    logic RESETN;
    logic HSEL = 1'b0;
    logic [7:0] HADDR = 8'h00;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0000_0000;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    pin_in_t PINS = {5'h01, 8'hFF};
    event_in_t EVENTS;
    cpu_req_t CPU_REQ;
    logic IRQ;
    logic [3:0] kick = 4'h0;
    logic slow = 1'b0;
    logic start_busy = 1'b0;
    logic dx_on = 1'b0;
    logic dx_cond = 1'b0;
    logic rd_pend = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 25;
    logic [7:0] r;
    logic [7:0] w;
    initial forever #50 MCLK = ~MCLK;
    irq_gather i_irq_gather
    (
        .MCLK(MCLK), .RESETN(RESETN), .CE(1'b1), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .PINS(PINS), .EVENTS(EVENTS), .CPU_REQ(CPU_REQ), .IRQ(IRQ)
    );
    irq_sources i_irq_sources
    (
        .clk(MCLK), .rst_n(RESETN), .kick(kick), .slow(slow), .start_busy(start_busy),
        .dx_on(dx_on), .dx_cond(dx_cond), .ev(EVENTS)
    );
    task automatic conclude;
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge MCLK);
    endtask
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge MCLK);
        HSEL <= 1'b1;
        HADDR <= a;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(a, 1'b0, 32'h0000_0000);
    endtask
    task automatic fire(input logic [3:0] k);
        @(posedge MCLK);
        kick <= k;
        @(posedge MCLK);
        kick <= 4'h0;
        idle(6);
    endtask
    // read data is taken at the data-phase edge, so the monitor owns it
    always @(posedge MCLK)
    begin
        cycles <= cycles + 1;
        if (rd_pend && HREADYOUT === 1'b1)
        begin
            check("HRDATA", exp_q[0] & msk_q[0], HRDATA & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        if (HREADYOUT === 1'b1)
            rd_pend <= HSEL && HTRANS[1] && !HWRITE;
        if (cycles > 3000)
        begin
            bad_count++;
            conclude();
        end
    end
    initial
    begin
        // driven after time 0 so the reset edge reaches every flop
        RESETN <= 1'b0;
        repeat (3) @(posedge MCLK);
        RESETN <= 1'b1;
        idle(3);
        rd(`OFS_FLAGS_ONE, 32'h0000_0020, 32'h0000_00FF);
        rd(`OFS_WAKEUP_FLAGS, 32'h0000_0000, 32'h0000_00FF);
        bus(`OFS_FLAGS_ONE, 1'b1, 32'h0000_00FF);
        bus(`OFS_WAKEUP_FLAGS, 1'b1, 32'h0000_00FF);
        rd(`OFS_FLAGS_ONE, 32'h0000_0020, 32'h0000_00FF);
        rd(`OFS_WAKEUP_FLAGS, 32'h0000_0000, 32'h0000_00FF);
        bus(`OFS_PIN_MODE, 1'b1, 32'h0000_1FFF);
        bus(`OFS_EDGE_CTRL, 1'b1, 32'h0000_001E);
        r = 8'($random(seed));
        r[0] = 1'b0;
        PINS.wakeup_pin <= r;
        idle(4);
        // slow sampling needs two ticks 16 cycles apart
        rd(`OFS_WAKEUP_FLAGS, 32'h0000_0000, 32'h0000_00FF);
        idle(70);
        rd(`OFS_WAKEUP_FLAGS, {24'h0, ~r}, 32'h0000_00FF);
        bus(`OFS_EDGE_CTRL, 1'b1, 32'h0000_001F);
        PINS.ext_pin <= 5'h1E;
        idle(10);
        rd(`OFS_FLAGS_ONE, 32'h0000_003F, 32'h0000_00FF);
        w = 8'($random(seed));
        bus(`OFS_WAKEUP_FLAGS, 1'b1, {24'h0, w});
        rd(`OFS_WAKEUP_FLAGS, {24'h0, ~r & w}, 32'h0000_00FF);
        bus(`OFS_WAKEUP_FLAGS, 1'b1, 32'h0000_0000);
        rd(`OFS_WAKEUP_FLAGS, 32'h0000_0000, 32'h0000_00FF);
        fire(4'h3);
        rd(`OFS_FLAGS_ONE, 32'h0000_00FF, 32'h0000_00FF);
        bus(`OFS_SRC_ENABLE, 1'b1, 32'h0000_0001);
        idle(3);
        check("CPU_REQ.src", 32'h0000_0001, {22'h0, CPU_REQ.src});
        bus(`OFS_SRC_ENABLE, 1'b1, 32'h0000_03FE);
        idle(3);
        check("CPU_REQ.src", 32'h0000_0002, {22'h0, CPU_REQ.src});
        start_busy <= 1'b1;
        slow <= 1'b1;
        fire(4'h4);
        start_busy <= 1'b0;
        dx_on <= 1'b1;
        fire(4'h8);
        rd(`OFS_FLAGS_TWO, 32'h0000_0000, 32'h0000_0003);
        dx_cond <= 1'b1;
        fire(4'hC);
        rd(`OFS_FLAGS_TWO, 32'h0000_0003, 32'h0000_0003);
        check("CPU_REQ.src", 32'h0000_0302, {22'h0, CPU_REQ.src});
        bus(`OFS_SRC_ENABLE, 1'b1, 32'h0000_0000);
        idle(3);
        check("CPU_REQ.src", 32'h0000_0000, {22'h0, CPU_REQ.src});
        bus(`OFS_IRQ_ENABLE, 1'b1, 32'h0000_0001);
        idle(3);
        check("IRQ", 32'h0000_0001, {31'h0, IRQ});
        bus(`OFS_IRQ_ENABLE, 1'b1, 32'h0000_0000);
        idle(3);
        check("IRQ", 32'h0000_0000, {31'h0, IRQ});
        bus(`OFS_IRQ_ENABLE, 1'b1, 32'h0000_0001);
        bus(`OFS_IRQ_CLEAR, 1'b1, 32'h0000_0001);
        idle(3);
        check("IRQ", 32'h0000_0000, {31'h0, IRQ});
        rd(`OFS_IRQ_STATUS, 32'h0000_0002, 32'h0000_0003);
        bus(8'h40, 1'b1, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
        bus(`OFS_FLAGS_ONE, 1'b1, 32'h0000_0000);
        bus(`OFS_FLAGS_TWO, 1'b1, 32'h0000_0000);
        rd(`OFS_FLAGS_ONE, 32'h0000_0020, 32'h0000_00FF);
        rd(`OFS_FLAGS_TWO, 32'h0000_0000, 32'h0000_0003);
        idle(70);
        conclude();
    end
endmodule
